// [hdl/pfg_top.sv]
// Fault selection, fault status and interrupt/trigger logic of one PWM generator.
// Assumes an APB master on sys_clk, trip pins from outside, and comparator trips and
// counter events as single-cycle levels or pulses from logic on sys_clk.
`timescale 1ns/1ns

// Overview of operation
// - Each trip has a readable status bit showing the live trip state.
// - In latched mode the status shows latched trip state instead.
// - Two trip groups: four external pins, eight comparator trips.
// - Per-group readable and writable trip selection mask.
// - After reset or without extended mode only external trip zero faults.
// - Extended mode takes fault sources from the masks software programs.
// - Fault is OR of selected trips, external ones sense adjusted first.
// - Six sticky event status bits, cleared by writing one.
// - Raw and masked interrupt status both readable.
// - Separate interrupt and trigger enables for each of six events.
// - Each external trip has a high or low active sense.
// - Latched versus unlatched fault mode per generator.
module pfg_top (
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [pfg_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic [pfg_pkg::EXT_TRIPS-1:0] external_trip_pin,
    input  wire logic [pfg_pkg::CMP_TRIPS-1:0] digital_comparator_trip,
    input  wire logic [pfg_pkg::EVENTS-1:0]    counter_event,
    output logic                              fault_out,
    output logic                              irq,
    output logic      [pfg_pkg::EVENTS-1:0]    trigger_out
);

    pfg_pkg::pfg_state_t st_r;
    pfg_pkg::pfg_state_t st_nxt;

    logic [pfg_pkg::EXT_TRIPS-1:0] ext_sync;

    // ==========================================================
    // Pin synchroniser
    pfg_sync #(
        .WIDTH (pfg_pkg::EXT_TRIPS)
    ) u_trip_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in (external_trip_pin),
        .sync_out (ext_sync)
    );

    // ==========================================================
    // Helpers

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    // Sticky bit update; a set in the clearing cycle survives
    function automatic logic [7:0] sticky(
        input logic [7:0] cur,
        input logic [7:0] set,
        input logic [7:0] clr
    );
        return (cur & ~clr) | set;
    endfunction

    // Known register offset
    function automatic logic addr_hit(input logic [pfg_pkg::ADDR_W-1:0] a);
        return (a == pfg_pkg::OFS_CTRL)     || (a == pfg_pkg::OFS_SENSE)  ||
               (a == pfg_pkg::OFS_TRIGSEL0) || (a == pfg_pkg::OFS_TRIGSEL1) ||
               (a == pfg_pkg::OFS_FSTAT0)   || (a == pfg_pkg::OFS_FSTAT1) ||
               (a == pfg_pkg::OFS_RIS)      || (a == pfg_pkg::OFS_MIS)    ||
               (a == pfg_pkg::OFS_INTEN);
    endfunction

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic                          access;
        logic                          wr_go;
        logic                          hit;
        logic [31:0]                   wmask;
        logic [31:0]                   wdat;
        logic [31:0]                   rdata;
        logic [31:0]                   merged;
        logic [pfg_pkg::EXT_TRIPS-1:0] ext_act;
        logic [pfg_pkg::EXT_TRIPS-1:0] rep_ext;
        logic [pfg_pkg::CMP_TRIPS-1:0] rep_cmp;
        logic [7:0]                    clr_ext;
        logic [7:0]                    clr_cmp;
        logic [7:0]                    clr_ris;
        logic [7:0]                    tmp;

        st_nxt  = st_r;
        rdata   = 32'h0000_0000;
        tmp     = 8'h00;
        access  = psel & penable;
        hit     = addr_hit(paddr);
        wr_go   = access & pwrite & st_r.pready & hit;
        wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        wdat    = pwdata & wmask;
        merged  = 32'h0000_0000;
        clr_ext = 8'h00;
        clr_cmp = 8'h00;
        clr_ris = 8'h00;

        ext_act = ext_sync ^ st_r.sense_low;

        rep_ext = st_r.latched_fault_mode ? st_r.latch_ext : ext_act;
        rep_cmp = st_r.latched_fault_mode ? st_r.latch_cmp : digital_comparator_trip;

        // Register writes, taken at the completing edge
        if (wr_go) begin
            unique case (paddr)
                pfg_pkg::OFS_CTRL: begin
                    merged = lane_merge({30'h0, st_r.extended_source_select_mode,
                                         st_r.latched_fault_mode}, pwdata, pstrb);
                    st_nxt.latched_fault_mode          = merged[pfg_pkg::CTRL_LATCH_BIT];
                    st_nxt.extended_source_select_mode = merged[pfg_pkg::CTRL_EXT_BIT];
                end
                pfg_pkg::OFS_SENSE: begin
                    merged = lane_merge({28'h0, st_r.sense_low}, pwdata, pstrb);
                    st_nxt.sense_low = merged[3:0];
                end
                pfg_pkg::OFS_TRIGSEL0: begin
                    merged = lane_merge({28'h0, st_r.sel_ext}, pwdata, pstrb);
                    st_nxt.sel_ext = merged[3:0];
                end
                pfg_pkg::OFS_TRIGSEL1: begin
                    merged = lane_merge({24'h0, st_r.sel_cmp}, pwdata, pstrb);
                    st_nxt.sel_cmp = merged[7:0];
                end
                pfg_pkg::OFS_FSTAT0: clr_ext = wdat[7:0];
                pfg_pkg::OFS_FSTAT1: clr_cmp = wdat[7:0];
                pfg_pkg::OFS_RIS:    clr_ris = wdat[7:0];
                pfg_pkg::OFS_INTEN: begin
                    merged = lane_merge({18'h0, st_r.trig_en, 2'h0, st_r.irq_en},
                                        pwdata, pstrb);
                    st_nxt.irq_en  = merged[pfg_pkg::INTEN_IRQ_LSB +: pfg_pkg::EVENTS];
                    st_nxt.trig_en = merged[pfg_pkg::INTEN_TRIG_LSB +: pfg_pkg::EVENTS];
                end
                default: begin
                    merged = 32'h0000_0000;
                end
            endcase
        end

        tmp = sticky({4'h0, st_r.latch_ext}, {4'h0, ext_act}, clr_ext);
        st_nxt.latch_ext = tmp[3:0];
        st_nxt.latch_cmp = sticky(st_r.latch_cmp, digital_comparator_trip, clr_cmp);

        if (st_r.extended_source_select_mode) begin
            st_nxt.fault = |(rep_ext & st_r.sel_ext) | |(rep_cmp & st_r.sel_cmp);
        end else begin
            st_nxt.fault = rep_ext[0];
        end

        tmp = sticky({2'h0, st_r.raw_irq}, {2'h0, counter_event}, clr_ris);
        st_nxt.raw_irq = tmp[5:0];

        st_nxt.irq = |(st_nxt.raw_irq & st_nxt.irq_en);

        st_nxt.trig = counter_event & st_r.trig_en;

        // Read mux
        unique case (paddr)
            pfg_pkg::OFS_CTRL:     rdata = {30'h0, st_r.extended_source_select_mode,
                                            st_r.latched_fault_mode};
            pfg_pkg::OFS_SENSE:    rdata = {28'h0, st_r.sense_low};
            pfg_pkg::OFS_TRIGSEL0: rdata = {28'h0, st_r.sel_ext};
            pfg_pkg::OFS_TRIGSEL1: rdata = {24'h0, st_r.sel_cmp};
            pfg_pkg::OFS_FSTAT0:   rdata = {28'h0, rep_ext};
            pfg_pkg::OFS_FSTAT1:   rdata = {24'h0, rep_cmp};
            pfg_pkg::OFS_RIS:      rdata = {26'h0, st_r.raw_irq};
            pfg_pkg::OFS_MIS:      rdata = {26'h0, st_r.raw_irq & st_r.irq_en};
            pfg_pkg::OFS_INTEN:    rdata = {18'h0, st_r.trig_en, 2'h0, st_r.irq_en};
            default:               rdata = 32'h0000_0000;
        endcase

        // One wait state keeps every bus output on a flop
        st_nxt.pready  = access & ~st_r.pready;
        st_nxt.pslverr = access & ~st_r.pready & ~hit;
        if (access & ~st_r.pready & ~pwrite) begin
            st_nxt.prdata = rdata;
        end else if (st_r.pready) begin
            st_nxt.prdata = 32'h0000_0000;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r                             <= '0;
            st_r.sense_low                   <= pfg_pkg::RST_SENSE;
            st_r.sel_ext                     <= pfg_pkg::RST_TRIGSEL0;
            st_r.sel_cmp                     <= pfg_pkg::RST_TRIGSEL1;
            st_r.irq_en                      <= pfg_pkg::RST_ENABLES;
            st_r.trig_en                     <= pfg_pkg::RST_ENABLES;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs straight from flops
    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign fault_out   = st_r.fault;
    assign irq         = st_r.irq;
    assign trigger_out = st_r.trig;

endmodule

// [hdl/pfg_pkg.sv]
// Constants and state type for the PWM generator fault and interrupt block.
// Assumes a 32-bit APB slave with byte addresses in paddr.
package pfg_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned EXT_TRIPS  = 4;
    localparam int unsigned CMP_TRIPS  = 8;
    localparam int unsigned EVENTS     = 6;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned SYNC_DEPTH = 2;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_SENSE    = 8'h04;
    localparam logic [7:0] OFS_TRIGSEL0 = 8'h08;
    localparam logic [7:0] OFS_TRIGSEL1 = 8'h0c;
    localparam logic [7:0] OFS_FSTAT0   = 8'h10;
    localparam logic [7:0] OFS_FSTAT1   = 8'h14;
    localparam logic [7:0] OFS_RIS      = 8'h18;
    localparam logic [7:0] OFS_MIS      = 8'h1c;
    localparam logic [7:0] OFS_INTEN    = 8'h20;

    // ==========================================================
    // Field positions
    localparam int unsigned CTRL_LATCH_BIT = 0;
    localparam int unsigned CTRL_EXT_BIT   = 1;
    localparam int unsigned INTEN_IRQ_LSB  = 0;
    localparam int unsigned INTEN_TRIG_LSB = 8;

    // Event bit order of status, enables and trigger outputs
    localparam int unsigned EV_ZERO   = 0;
    localparam int unsigned EV_LOAD   = 1;
    localparam int unsigned EV_A_UP   = 2;
    localparam int unsigned EV_A_DOWN = 3;
    localparam int unsigned EV_B_UP   = 4;
    localparam int unsigned EV_B_DOWN = 5;

    // ==========================================================
    // Reset values
    localparam logic [3:0] RST_SENSE   = 4'h0;
    localparam logic [3:0] RST_TRIGSEL0 = 4'h1;
    localparam logic [7:0] RST_TRIGSEL1 = 8'h00;
    localparam logic [5:0] RST_ENABLES = 6'h00;

    // ==========================================================
    // Whole state of the top module
    typedef struct packed {
        logic                 latched_fault_mode;
        logic                 extended_source_select_mode;
        logic [EXT_TRIPS-1:0] sense_low;
        logic [EXT_TRIPS-1:0] sel_ext;
        logic [CMP_TRIPS-1:0] sel_cmp;
        logic [EXT_TRIPS-1:0] latch_ext;
        logic [CMP_TRIPS-1:0] latch_cmp;
        logic [EVENTS-1:0]    raw_irq;
        logic [EVENTS-1:0]    irq_en;
        logic [EVENTS-1:0]    trig_en;
        logic                 fault;
        logic                 irq;
        logic [EVENTS-1:0]    trig;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
    } pfg_state_t;

endpackage

// [hdl/pfg_sync.sv]
// Two-flop synchroniser for a group of level inputs from pins.
// Assumes the inputs are quasi-static levels; no edge is preserved.
`timescale 1ns/1ns

module pfg_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pfg_sync_state_t;

    pfg_sync_state_t st_r;
    pfg_sync_state_t st_nxt;

    // ==========================================================
    // Stage one feeds only stage two
    always_comb begin
        st_nxt        = st_r;
        st_nxt.stage1 = async_in;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage2;

endmodule

// [testbench/pfg_top_asserts.sv]
// Port-level assertions for the generator fault and interrupt block.
// Assumes it is bound to pfg_top from the bench top file.
`timescale 1ns/1ns

module pfg_top_asserts (
    input wire logic                           sys_clk,
    input wire logic                           reset_n,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [pfg_pkg::ADDR_W-1:0]     paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [3:0]                     pstrb,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic [pfg_pkg::EXT_TRIPS-1:0]  external_trip_pin,
    input wire logic [pfg_pkg::CMP_TRIPS-1:0]  digital_comparator_trip,
    input wire logic [pfg_pkg::EVENTS-1:0]     counter_event,
    input wire logic                           fault_out,
    input wire logic                           irq,
    input wire logic [pfg_pkg::EVENTS-1:0]     trigger_out
);
    // ==========================================================
    // Helpers
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence

    // ==========================================================
    // Bus answer
    a_ready_one_wait: assert property (s_access |=> s_answer)
        else $error("pready not a single pulse after access");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (pready && paddr > pfg_pkg::OFS_INTEN |-> pslverr)
        else $error("unmapped address answered without error");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero outside answer");

    // ==========================================================
    // Events, interrupt and triggers
    a_trig_has_cause: assert property ((trigger_out & ~$past(counter_event)) == 6'h00)
        else $error("trigger pulse without counter event");
    a_irq_fall_write: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("interrupt dropped without a register write");
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(|counter_event) || $past(wr_done) || $past(wr_done, 2))
        else $error("interrupt rose without event or write");
    a_trig_one_cycle: assert property ($rose(trigger_out[0]) && !counter_event[0]
        |=> !trigger_out[0])
        else $error("trigger held after event ended");
endmodule

// [testbench/pfg_top_bench.sv]
// Self-checking bench for the generator fault and interrupt block.
// Assumes pfg_pkg and pfg_top are compiled first; drives APB itself.
`timescale 1ns/1ns

module pfg_top_bench;
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0]  pstrb = 4'hf, pins = 4'h0;
    logic [7:0]  cmp = 8'h00;
    logic [5:0]  ev = 6'h00, trig;
    logic        pready, pslverr, fault, irq;
    int          bad_count = 0, samples_checked = 0;

    pfg_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_trip_pin(pins),
        .digital_comparator_trip(cmp), .counter_event(ev), .fault_out(fault), .irq(irq),
        .trigger_out(trig));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // ==========================================================
    // APB master; returns one cycle after the answer edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic        err;
        apb(1'b0, a, 32'h0, v, err);
        chk(what, v, exp);
        chk({what, " err"}, {31'h0, err}, {31'h0, (a > pfg_pkg::OFS_INTEN)});
    endtask
    // Trigger is collected over a few edges so one-cycle pulses are not missed
    task automatic fire(input int i, input logic [5:0] exp);
        logic [5:0] acc;
        int         hi;
        acc = 6'h00; hi = 0;
        ev <= 6'h01 << i;
        @(posedge sys_clk);
        ev <= 6'h00;
        repeat (3) begin
            @(posedge sys_clk);
            acc |= trig;
            hi += (trig != 6'h00);
        end
        chk("trigger", {26'h0, acc}, {26'h0, exp});
        chk("trigger cycles", hi, (exp != 6'h00));
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        cycles(16);
        reset_n <= 1'b1;
        cycles(2);
        // Reset values of every register but the two fault status ones, one unmapped place
        rd("ctrl", pfg_pkg::OFS_CTRL, 32'h0);
        rd("sense", pfg_pkg::OFS_SENSE, 32'h0);
        rd("sel0", pfg_pkg::OFS_TRIGSEL0, 32'h1);
        rd("sel1", pfg_pkg::OFS_TRIGSEL1, 32'h0);
        rd("ris", pfg_pkg::OFS_RIS, 32'h0);
        rd("mis", pfg_pkg::OFS_MIS, 32'h0);
        rd("inten", pfg_pkg::OFS_INTEN, 32'h0);
        rd("unmapped", 8'h24, 32'h0);
        $display("reset values done");
        // Legacy mode ignores masks: only trip pin zero counts
        wr(pfg_pkg::OFS_TRIGSEL1, 32'hff);
        rd("sel1 rw", pfg_pkg::OFS_TRIGSEL1, 32'hff);
        cmp <= 8'hff; pins <= 4'h2;
        cycles(5);
        chk("fault legacy", fault, 1'b0);
        rd("fstat0 live", pfg_pkg::OFS_FSTAT0, 32'h2);
        rd("fstat1 live", pfg_pkg::OFS_FSTAT1, 32'hff);
        cmp <= 8'h00; pins <= 4'h3;
        cycles(5);
        chk("fault pin0", fault, 1'b1);
        wr(pfg_pkg::OFS_SENSE, 32'h1);
        cycles(4);
        chk("fault sense low", fault, 1'b0);
        rd("fstat0 sensed", pfg_pkg::OFS_FSTAT0, 32'h2);
        pins <= 4'h0;
        cycles(5);
        chk("fault low asserted", fault, 1'b1);
        wr(pfg_pkg::OFS_SENSE, 32'h0);
        $display("legacy and sense done");
        // Extended mode: OR of selected trips only
        wr(pfg_pkg::OFS_CTRL, 32'h2);
        wr(pfg_pkg::OFS_TRIGSEL0, 32'h4);
        wr(pfg_pkg::OFS_TRIGSEL1, 32'h80);
        cmp <= 8'h7f; pins <= 4'hb;
        cycles(5);
        chk("fault unselected", fault, 1'b0);
        cmp <= 8'h80;
        cycles(3);
        chk("fault cmp7", fault, 1'b1);
        cmp <= 8'h00; pins <= 4'h4;
        cycles(5);
        chk("fault pin2", fault, 1'b1);
        pins <= 4'h0;
        cycles(5);
        // Unlatched: a short trip leaves no status
        cmp <= 8'h80;
        @(posedge sys_clk);
        cmp <= 8'h00;
        cycles(3);
        rd("fstat1 unlatched", pfg_pkg::OFS_FSTAT1, 32'h0);
        wr(pfg_pkg::OFS_FSTAT1, 32'hff);
        wr(pfg_pkg::OFS_FSTAT0, 32'hf);
        wr(pfg_pkg::OFS_CTRL, 32'h3);
        cmp <= 8'h80;
        @(posedge sys_clk);
        cmp <= 8'h00;
        cycles(3);
        rd("fstat1 latched", pfg_pkg::OFS_FSTAT1, 32'h80);
        chk("fault latched", fault, 1'b1);
        wr(pfg_pkg::OFS_FSTAT1, 32'h80);
        cycles(2);
        rd("fstat1 cleared", pfg_pkg::OFS_FSTAT1, 32'h0);
        chk("fault cleared", fault, 1'b0);
        // Only enabled byte lanes of a write land
        pstrb <= 4'he;
        wr(pfg_pkg::OFS_TRIGSEL1, 32'h0);
        pstrb <= 4'hf;
        rd("sel1 lanes", pfg_pkg::OFS_TRIGSEL1, 32'h80);
        $display("extended and latched done");
        // Each event: status, masked status, interrupt, trigger
        for (int i = 0; i < 6; i++) begin
            wr(pfg_pkg::OFS_INTEN, (32'h1 << i) | (32'h100 << i));
            fire(i, 6'h01 << i);
            chk("irq set", irq, 1'b1);
            rd("ris", pfg_pkg::OFS_RIS, 32'h1 << i);
            rd("mis", pfg_pkg::OFS_MIS, 32'h1 << i);
            wr(pfg_pkg::OFS_RIS, 32'h0);
            rd("ris zero write", pfg_pkg::OFS_RIS, 32'h1 << i);
            wr(pfg_pkg::OFS_RIS, 32'h1 << i);
            cycles(2);
            chk("irq cleared", irq, 1'b0);
            rd("ris cleared", pfg_pkg::OFS_RIS, 32'h0);
        end
        // Masked event still sets raw status
        wr(pfg_pkg::OFS_INTEN, 32'h0);
        fire(1, 6'h00);
        rd("ris masked", pfg_pkg::OFS_RIS, 32'h2);
        rd("mis masked", pfg_pkg::OFS_MIS, 32'h0);
        wr(pfg_pkg::OFS_MIS, 32'h3f);
        rd("ris after mis write", pfg_pkg::OFS_RIS, 32'h2);
        chk("irq masked", irq, 1'b0);
        wr(pfg_pkg::OFS_INTEN, 32'h2);
        cycles(2);
        chk("irq unmasked", irq, 1'b1);
        wr(pfg_pkg::OFS_RIS, 32'h2);
        $display("interrupts and triggers done");
        close_out();
    end
endmodule

bind pfg_top pfg_top_asserts chk_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trip_pin(external_trip_pin),
    .digital_comparator_trip(digital_comparator_trip), .counter_event(counter_event),
    .fault_out(fault_out), .irq(irq), .trigger_out(trigger_out));
